// File: verif/acsif_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module acsif_host_model (
    input  wire logic                  clk,
    input  wire logic                  rd_ack,
    input  wire logic [7:0]            rd_data,
    output var  acsif_pkg::acsif_req_s req
);
    initial req = '0;
    //////////////////////////////////////////////////////////////////////////
    // Read: strobe over one edge, take data with the acknowledge
    task automatic read(input logic [7:0] addr, output logic [7:0] data, output logic ok);
        ok = 1'b0;
        data = 8'h00;
        req.rd = 1'b1;
        req.addr = addr;
        @(negedge clk);
        req.rd = 1'b0;
        req.addr = ~addr;
        repeat (4) begin
            if (!ok && rd_ack === 1'b1) begin
                ok = 1'b1;
                data = rd_data;
            end
            if (!ok) @(negedge clk);
        end
        @(negedge clk);
    endtask
    // Write: used by the host to clear flags where selected
    task automatic write(input logic [7:0] addr, input logic [7:0] data);
        req.wr = 1'b1;
        req.addr = addr;
        req.wdata = data;
        @(negedge clk);
        req.wr = 1'b0;
        req.addr = ~addr;
        req.wdata = ~data;
        @(negedge clk);
    endtask
endmodule
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic                  clk = 1'b0;
    logic                  rst_b = 1'b0;
    acsif_pkg::acsif_req_s req;
    acsif_pkg::acsif_cfg_s cfg;
    logic                  mode_cmd_wr = 1'b0;
    logic [2:0]            mode_cmd = 3'h0;
    logic                  new_sample = 1'b0;
    logic                  activity = 1'b0;
    logic [5:0]            fifo_count = 6'h00;
    logic [7:0]            rd_data;
    logic                  rd_ack;
    logic [2:0]            mode_code;
    logic                  flag_pending;
    logic                  detector_run;
    logic                  pipeline_run;
    logic                  fifo_run;
    int                    bad_count = 0;
    int                    num_checks = 0;
    logic [2:0]            codes [6] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7, 3'h0};

    always #2 clk = ~clk;

    acsif_status_flags #(.HB_DIV(2)) acsif_status_flags_i (
        .clk(clk), .rst_b(rst_b), .req(req), .cfg(cfg), .mode_cmd_wr(mode_cmd_wr),
        .mode_cmd(mode_cmd), .new_sample(new_sample), .activity(activity),
        .fifo_count(fifo_count), .rd_data(rd_data), .rd_ack(rd_ack), .mode_code(mode_code),
        .flag_pending(flag_pending), .detector_run(detector_run),
        .pipeline_run(pipeline_run), .fifo_run(fifo_run)
    );
    acsif_host_model acsif_host_model_i (
        .clk(clk), .rd_ack(rd_ack), .rd_data(rd_data), .req(req)
    );

    //////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        logic [7:0] d;
        logic       ok;
        acsif_host_model_i.read(a, d, ok);
        if (!ok) begin
            bad_count++;
            $display("CHECK FAILED %s ack expected 1 seen 0", name);
            conclude();
        end else begin
            chk(name, exp, d);
        end
    endtask
    task automatic set_mode(input logic [2:0] code, input logic [2:0] exp);
        int n;
        n = 0;
        mode_cmd_wr = 1'b1;
        mode_cmd = code;
        @(negedge clk);
        mode_cmd_wr = 1'b0;
        while (mode_code !== exp && n < 6) begin
            @(negedge clk);
            n++;
        end
        chk("mode_code", {5'h00, exp}, {5'h00, mode_code});
        if (mode_code !== exp) conclude();
    endtask
    task automatic sample();
        new_sample = 1'b1;
        @(negedge clk);
        new_sample = 1'b0;
        @(negedge clk);
    endtask
    task automatic act();
        activity = 1'b1;
        @(negedge clk);
        activity = 1'b0;
        @(negedge clk);
    endtask
    //////////////////////////////////////////////////////////////////////////
    task automatic s_modes();
        foreach (codes[i]) begin
            set_mode(codes[i], codes[i]);
            chk("run", {5'h00, codes[i] >= 3'h5, codes[i] == 3'h2 || codes[i] == 3'h6,
                codes[i] >= 3'h5}, {5'h00, fifo_run, detector_run, pipeline_run});
        end
        set_mode(3'h3, 3'h0);
        repeat (8) @(negedge clk);
        chk("reserved", 8'h00, {5'h00, mode_code});
    endtask
    task automatic s_acq();
        cfg.int_en = 8'hFC;
        cfg.fifo_en = 1'b0;
        set_mode(3'h5, 3'h5);
        chk("fifo off", 8'h00, {7'h00, fifo_run});
        sample();
        chk("pending", 8'h01, {7'h00, flag_pending});
        rd(8'h09, 8'h08, "acq flag");
        rd(8'h09, 8'h00, "read clear");
        rd(8'h08, 8'h1D, "sample bit");
        rd(8'h08, 8'h15, "sample read");
        cfg.int_en = 8'h00;
        sample();
        rd(8'h09, 8'h00, "disabled");
        rd(8'h08, 8'h1D, "sample noen");
        cfg.int_en = 8'hFC;
    endtask
    task automatic s_wake();
        set_mode(3'h2, 3'h2);
        act();
        chk("auto mode", 8'h05, {5'h00, mode_code});
        cfg.i2c_write_clear = 1'b1;
        rd(8'h09, 8'h04, "wake flag");
        rd(8'h09, 8'h04, "i2c read kept");
        acsif_host_model_i.write(8'h09, 8'h00);
        cfg.i2c_write_clear = 1'b0;
        rd(8'h09, 8'h00, "wake clear");
    endtask
    task automatic s_fifo();
        cfg.spi_sel = 1'b1;
        fifo_count = 6'h05;
        repeat (2) @(negedge clk);
        rd(8'h08, 8'hC5, "over");
        rd(8'h09, 8'h40, "level flag");
        rd(8'h09, 8'h40, "spi read");
        acsif_host_model_i.write(8'h09, 8'h00);
        rd(8'h09, 8'h00, "spi clear");
        fifo_count = 6'h20;
        repeat (2) @(negedge clk);
        rd(8'h09, 8'h20, "full flag");
        rd(8'h08, 8'hE5, "full bit");
        fifo_count = 6'h00;
        repeat (2) @(negedge clk);
        rd(8'h09, 8'h30, "empty flag");
        rd(8'h08, 8'h95, "empty bit");
        acsif_host_model_i.write(8'h09, 8'h00);
        repeat (3) @(negedge clk);
        rd(8'h09, 8'h00, "no rearm");
        cfg.spi_sel = 1'b0;
    endtask
    task automatic s_comb();
        set_mode(3'h6, 3'h6);
        sample();
        act();
        chk("disarmed", 8'h00, {7'h00, detector_run});
        rd(8'h09, 8'h80, "comb flag");
        chk("kept off", 8'h00, {7'h00, detector_run});
        act();
        rd(8'h09, 8'h00, "ignored");
        cfg.rearm_detector_on_clear = 1'b1;
        set_mode(3'h5, 3'h5);
        set_mode(3'h6, 3'h6);
        chk("mode rearm", 8'h01, {7'h00, detector_run});
        act();
        rd(8'h09, 8'h80, "comb again");
        @(negedge clk);
        chk("clear rearm", 8'h01, {7'h00, detector_run});
    endtask
    task automatic s_burst();
        cfg.burst_len = 8'h02;
        set_mode(3'h7, 3'h7);
        sample();
        chk("burst on", 8'h07, {5'h00, mode_code});
        sample();
        chk("burst end", 8'h00, {5'h00, mode_code});
        rd(8'h09, 8'h08, "burst acq");
        cfg.burst_len = 8'h00;
        set_mode(3'h7, 3'h7);
        repeat (3) sample();
        chk("endless", 8'h07, {5'h00, mode_code});
    endtask
    //////////////////////////////////////////////////////////////////////////
    initial begin
        cfg = '0;
        cfg.fifo_over_threshold = 5'h05;
        cfg.fifo_en = 1'b1;
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        rd(8'h08, 8'h10, "status one");
        rd(8'h09, 8'h00, "status two");
        s_modes();
        s_acq();
        s_wake();
        s_fifo();
        s_comb();
        s_burst();
        conclude();
    end
endmodule
`default_nettype wire

// File: verilog/acsif_flag_cell.sv
`timescale 1ns/1ps
`default_nettype none
module acsif_flag_cell (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic set_evt,
    input  wire logic enable,
    input  wire logic clear,
    output var  logic flag
);

    // Sticky flag, a set in the clear cycle wins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flag <= 1'b0;
        end else if (set_evt && enable) begin
            flag <= 1'b1;
        end else if (clear) begin
            flag <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// File: verilog/acsif_pkg.sv
`default_nettype none
package acsif_pkg;

    //////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] ADDR_MODE_STATUS = 8'h08;
    localparam logic [7:0] ADDR_FLAG_STATUS = 8'h09;

    // Reset values
    localparam logic [7:0] RST_MODE_STATUS = 8'h00;
    localparam logic [7:0] RST_FLAG_STATUS = 8'h00;
    localparam logic [7:0] RD_IDLE         = 8'h00;

    //////////////////////////////////////////////////////////////////////////
    // Mode and FIFO status field positions
    localparam int MS_MODE_LSB  = 0;
    localparam int MS_MODE_MSB  = 2;
    localparam int MS_SAMPLE    = 3;
    localparam int MS_EMPTY     = 4;
    localparam int MS_FULL      = 5;
    localparam int MS_OVER      = 6;
    localparam int MS_PENDING   = 7;

    // Interrupt flag field positions
    localparam int FL_LOW       = 2;
    localparam int FL_WAKE      = 2;
    localparam int FL_ACQ       = 3;
    localparam int FL_EMPTY     = 4;
    localparam int FL_FULL      = 5;
    localparam int FL_LEVEL     = 6;
    localparam int FL_COMBINED  = 7;

    //////////////////////////////////////////////////////////////////////////
    // Mode codes; CODE_RESV_A and CODE_RESV_B are never reported
    localparam logic [2:0] CODE_SLEEP    = 3'h0;
    localparam logic [2:0] CODE_STANDBY  = 3'h1;
    localparam logic [2:0] CODE_WATCH    = 3'h2;
    localparam logic [2:0] CODE_RESV_A   = 3'h3;
    localparam logic [2:0] CODE_RESV_B   = 3'h4;
    localparam logic [2:0] CODE_CONT     = 3'h5;
    localparam logic [2:0] CODE_COMBINED = 3'h6;
    localparam logic [2:0] CODE_BURST    = 3'h7;

    //////////////////////////////////////////////////////////////////////////
    // Timing and sizes
    localparam int         MODE_LAG_EDGES = 3;
    localparam int         HB_DIV_DEFAULT = 4;
    localparam logic [5:0] FIFO_DEPTH     = 6'h20;
    localparam logic [7:0] BURST_MAX      = 8'hFE;
    localparam logic [7:0] BURST_ENDLESS  = 8'h00;

    typedef enum logic [2:0] {
        M_SLEEP,
        M_STANDBY,
        M_WATCH,
        M_CONT,
        M_COMBINED,
        M_BURST
    } acsif_mode_e;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } acsif_req_s;

    typedef struct packed {
        logic [7:0] int_en;
        logic [4:0] fifo_over_threshold;
        logic       rearm_detector_on_clear;
        logic       i2c_write_clear;
        logic       spi_sel;
        logic       fifo_en;
        logic [7:0] burst_len;
    } acsif_cfg_s;

endpackage
`default_nettype wire

// File: verilog/acsif_status_flags.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE_01: Reported mode follows a new command within three heartbeat edges.
// RULE_02: Mode codes 000,001,010,101,110,111; 011 and 100 never reported.
// RULE_03: Activity watch samples only for detection, moves itself to continuous on activity.
// RULE_04: Counted burst takes 1 to 254 samples or endless, then returns to sleep.
// RULE_05: Combined mode runs detector, pipeline, optional FIFO; continuous has detector off.
// RULE_06: Sample-arrived bit set by each new sample, cleared by reading, enable-independent.
// RULE_07: FIFO-empty bit is high while FIFO holds nothing, high after reset.
// RULE_08: Over-threshold bit is high while stored count is at or above threshold.
// RULE_09: FIFO-full bit is high while all 32 entries are occupied.
// RULE_10: Pending bit is the OR of all interrupt flags.
// RULE_11: An interrupt flag sets only when its enable bit is one.
// RULE_12: Flags clear on read (I2C default), on write (I2C option or SPI).
// RULE_13: Wake flag sets on each automatic watch-to-continuous move.
// RULE_14: Acquisition flag sets on a new sample in continuous or burst mode only.
// RULE_15: FIFO-empty flag sets when FIFO becomes empty again.
// RULE_16: FIFO-full flag sets when FIFO enters the full state again.
// RULE_17: FIFO-level flag sets when count reaches or passes the threshold.
// RULE_18: Combined flag sets on detection in combined mode; detector then ignores events.
// RULE_19: Optionally the detector is reset in the same cycle the combined flag clears.
// RULE_20: Without re-arm on clear, only leaving combined mode re-arms the detector.
// RULE_21: Status registers read zero after reset except empty bit; reserved bits zero.
module acsif_status_flags #(
    parameter int HB_DIV = acsif_pkg::HB_DIV_DEFAULT
) (
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire acsif_pkg::acsif_req_s req,
    input  wire acsif_pkg::acsif_cfg_s cfg,
    input  wire logic                  mode_cmd_wr,
    input  wire logic [2:0]            mode_cmd,
    input  wire logic                  new_sample,
    input  wire logic                  activity,
    input  wire logic [5:0]            fifo_count,
    output var  logic [7:0]            rd_data,
    output var  logic                  rd_ack,
    output logic [2:0]                 mode_code,
    output logic                       flag_pending,
    output logic                       detector_run,
    output logic                       pipeline_run,
    output logic                       fifo_run
);

    localparam int HB_W    = (HB_DIV > 1) ? $clog2(HB_DIV) : 1;
    localparam int LAG_MAX = HB_DIV * acsif_pkg::MODE_LAG_EDGES;
    localparam logic [HB_W-1:0] HB_LAST = HB_W'(HB_DIV - 1);

    logic [HB_W-1:0]       hb_cnt;
    logic                  hb_tick;
    acsif_pkg::acsif_mode_e mode;
    acsif_pkg::acsif_mode_e cmd_mode;
    logic                  cmd_pend;
    logic                  cmd_apply;
    logic                  auto_wake;
    logic [7:0]            burst_cnt;
    logic [7:0]            burst_goal;
    logic                  burst_done;
    logic                  samp_ok;
    logic                  armed;
    logic                  comb_evt;
    logic                  sample_arrived;
    logic                  lvl_empty;
    logic                  lvl_full;
    logic                  lvl_over;
    logic                  prev_empty;
    logic                  prev_full;
    logic                  prev_over;
    logic                  clear_evt;
    logic [7:0]            evt;
    logic [7:0]            flags;
    logic [7:0]            mode_status;
    logic [7:0]            en_q;
    logic [7:0]            flags_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    //////////////////////////////////////////////////////////////////////////
    // Mode code helpers
    function automatic logic code_valid(input logic [2:0] c);
        return (c != acsif_pkg::CODE_RESV_A) && (c != acsif_pkg::CODE_RESV_B);
    endfunction

    function automatic acsif_pkg::acsif_mode_e decode(input logic [2:0] c);
        acsif_pkg::acsif_mode_e m;
        m = acsif_pkg::M_SLEEP;
        case (c)
            acsif_pkg::CODE_STANDBY:  m = acsif_pkg::M_STANDBY;
            acsif_pkg::CODE_WATCH:    m = acsif_pkg::M_WATCH;
            acsif_pkg::CODE_CONT:     m = acsif_pkg::M_CONT;
            acsif_pkg::CODE_COMBINED: m = acsif_pkg::M_COMBINED;
            acsif_pkg::CODE_BURST:    m = acsif_pkg::M_BURST;
            default:                  m = acsif_pkg::M_SLEEP;
        endcase
        return m;
    endfunction

    function automatic logic [2:0] encode(input acsif_pkg::acsif_mode_e m);
        logic [2:0] c;
        c = acsif_pkg::CODE_SLEEP;
        case (m)
            acsif_pkg::M_STANDBY:  c = acsif_pkg::CODE_STANDBY;
            acsif_pkg::M_WATCH:    c = acsif_pkg::CODE_WATCH;
            acsif_pkg::M_CONT:     c = acsif_pkg::CODE_CONT;
            acsif_pkg::M_COMBINED: c = acsif_pkg::CODE_COMBINED;
            acsif_pkg::M_BURST:    c = acsif_pkg::CODE_BURST;
            default:               c = acsif_pkg::CODE_SLEEP;
        endcase
        return c;
    endfunction

    function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ref_a);
        return a == ref_a;
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // Heartbeat divider
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hb_cnt <= '0;
        end else if (hb_tick) begin
            hb_cnt <= '0;
        end else begin
            hb_cnt <= hb_cnt + HB_W'(1);
        end
    end

    assign hb_tick = (hb_cnt == HB_LAST);

    //////////////////////////////////////////////////////////////////////////
    // Mode command holding
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_pend <= 1'b0;
            cmd_mode <= acsif_pkg::M_SLEEP;
        end else if (mode_cmd_wr && code_valid(mode_cmd)) begin
            cmd_pend <= 1'b1;
            cmd_mode <= decode(mode_cmd);
        end else if (hb_tick) begin
            cmd_pend <= 1'b0;
        end
    end

    assign cmd_apply = cmd_pend && hb_tick && !(mode_cmd_wr && code_valid(mode_cmd));
    assign auto_wake = (mode == acsif_pkg::M_WATCH) && activity && !cmd_apply;

    // Mode state
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode <= acsif_pkg::M_SLEEP;
        end else if (cmd_apply) begin
            mode <= cmd_mode; // RULE_01
        end else begin
            case (mode)
                acsif_pkg::M_WATCH: begin
                    if (activity) begin
                        mode <= acsif_pkg::M_CONT; // RULE_03
                    end
                end
                acsif_pkg::M_BURST: begin
                    if (burst_done) begin
                        mode <= acsif_pkg::M_SLEEP; // RULE_04
                    end
                end
                default: begin
                    mode <= mode;
                end
            endcase
        end
    end

    assign mode_code = encode(mode); // RULE_02

    //////////////////////////////////////////////////////////////////////////
    // Sampling pipeline and burst counting
    assign pipeline_run = (mode == acsif_pkg::M_CONT) || (mode == acsif_pkg::M_COMBINED)
                        || (mode == acsif_pkg::M_BURST);
    assign fifo_run     = pipeline_run && cfg.fifo_en; // RULE_05
    assign samp_ok      = new_sample && pipeline_run; // RULE_03
    assign burst_goal   = (cfg.burst_len > acsif_pkg::BURST_MAX) ? acsif_pkg::BURST_MAX
                        : cfg.burst_len;
    assign burst_done   = (mode == acsif_pkg::M_BURST) && samp_ok && !cmd_apply
                        && (burst_goal != acsif_pkg::BURST_ENDLESS)
                        && (burst_cnt + 8'h01 >= burst_goal); // RULE_04

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            burst_cnt <= 8'h00;
        end else if (mode != acsif_pkg::M_BURST) begin
            burst_cnt <= 8'h00;
        end else if (samp_ok && burst_cnt != 8'hFF) begin
            burst_cnt <= burst_cnt + 8'h01;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Activity detector arming
    assign detector_run = (mode == acsif_pkg::M_WATCH)
                        || ((mode == acsif_pkg::M_COMBINED) && armed); // RULE_05
    assign comb_evt     = (mode == acsif_pkg::M_COMBINED) && armed && activity; // RULE_18

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            armed <= 1'b1;
        end else if (comb_evt) begin
            armed <= 1'b0; // RULE_18
        end else if (mode != acsif_pkg::M_COMBINED) begin
            armed <= 1'b1; // RULE_20
        end else if (clear_evt && cfg.rearm_detector_on_clear) begin
            armed <= 1'b1; // RULE_19
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // FIFO levels and edges
    assign lvl_empty = (fifo_count == 6'h00); // RULE_07
    assign lvl_full  = (fifo_count == acsif_pkg::FIFO_DEPTH); // RULE_09
    assign lvl_over  = (fifo_count >= {1'b0, cfg.fifo_over_threshold}); // RULE_08

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_empty <= 1'b1;
            prev_full  <= 1'b0;
            prev_over  <= 1'b0;
        end else begin
            prev_empty <= lvl_empty;
            prev_full  <= lvl_full;
            prev_over  <= lvl_over;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Sample arrived bit
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sample_arrived <= 1'b0;
        end else if (samp_ok) begin
            sample_arrived <= 1'b1; // RULE_06
        end else if (req.rd && is_addr(req.addr, acsif_pkg::ADDR_MODE_STATUS)) begin
            sample_arrived <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Interrupt flags
    assign clear_evt = is_addr(req.addr, acsif_pkg::ADDR_FLAG_STATUS)
                     && ((req.rd && !cfg.spi_sel && !cfg.i2c_write_clear)
                     || (req.wr && (cfg.spi_sel || cfg.i2c_write_clear))); // RULE_12

    always_comb begin
        evt = 8'h00;
        evt[acsif_pkg::FL_WAKE]     = auto_wake; // RULE_13
        evt[acsif_pkg::FL_ACQ]      = samp_ok && ((mode == acsif_pkg::M_CONT)
                                    || (mode == acsif_pkg::M_BURST)); // RULE_14
        evt[acsif_pkg::FL_EMPTY]    = lvl_empty && !prev_empty; // RULE_15
        evt[acsif_pkg::FL_FULL]     = lvl_full && !prev_full; // RULE_16
        evt[acsif_pkg::FL_LEVEL]    = lvl_over && !prev_over; // RULE_17
        evt[acsif_pkg::FL_COMBINED] = comb_evt; // RULE_18
    end

    assign flags[acsif_pkg::FL_LOW-1:0] = '0; // RULE_21

    generate
        for (genvar i = acsif_pkg::FL_LOW; i < 8; i++) begin : g_flag
            acsif_flag_cell u_cell (
                .clk     (clk),
                .rst_b   (rst_b),
                .set_evt (evt[i]),
                .enable  (cfg.int_en[i]), // RULE_11
                .clear   (clear_evt),
                .flag    (flags[i])
            );
        end
    endgenerate

    assign flag_pending = |flags; // RULE_10

    //////////////////////////////////////////////////////////////////////////
    // Register read port
    always_comb begin
        mode_status = acsif_pkg::RST_MODE_STATUS;
        mode_status[acsif_pkg::MS_MODE_MSB:acsif_pkg::MS_MODE_LSB] = mode_code;
        mode_status[acsif_pkg::MS_SAMPLE]  = sample_arrived;
        mode_status[acsif_pkg::MS_EMPTY]   = lvl_empty;
        mode_status[acsif_pkg::MS_FULL]    = lvl_full;
        mode_status[acsif_pkg::MS_OVER]    = lvl_over;
        mode_status[acsif_pkg::MS_PENDING] = flag_pending;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= acsif_pkg::RD_IDLE;
            rd_ack  <= 1'b0;
        end else begin
            rd_ack <= req.rd;
            if (req.rd) begin
                case (req.addr)
                    acsif_pkg::ADDR_MODE_STATUS: rd_data <= mode_status;
                    acsif_pkg::ADDR_FLAG_STATUS: rd_data <= flags;
                    default:                     rd_data <= acsif_pkg::RD_IDLE;
                endcase
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Checks
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            en_q    <= 8'h00;
            flags_q <= 8'h00;
        end else begin
            en_q    <= cfg.int_en;
            flags_q <= flags;
        end
    end

    sequence s_watch_hit;
        (mode == acsif_pkg::M_WATCH) && activity && !cmd_apply;
    endsequence

    sequence s_woken;
        (mode == acsif_pkg::M_CONT) && !detector_run;
    endsequence

    AST_MODE_LAG: assert property (cmd_pend |-> ##[0:LAG_MAX] !cmd_pend) // RULE_01
        else $error("mode command not applied in time");
    AST_MODE_TAKE: assert property ($fell(cmd_pend) |-> mode == cmd_mode) // RULE_01
        else $error("reported mode differs from command");
    AST_CODE_RESV: assert property (mode_code != acsif_pkg::CODE_RESV_A
        && mode_code != acsif_pkg::CODE_RESV_B) // RULE_02
        else $error("reserved mode code reported");
    AST_WATCH_WAKE: assert property (s_watch_hit |=> s_woken
        and (flags[acsif_pkg::FL_WAKE] == en_q[acsif_pkg::FL_WAKE]
        || flags_q[acsif_pkg::FL_WAKE])) // RULE_13
        else $error("watch to continuous move wrong");
    AST_BURST_END: assert property (burst_done |=> mode == acsif_pkg::M_SLEEP) // RULE_04
        else $error("burst did not return to sleep");
    AST_SAMPLE_BIT: assert property (samp_ok |=> mode_status[acsif_pkg::MS_SAMPLE]) // RULE_06
        else $error("sample arrived bit missing");
    AST_PENDING: assert property (req.rd && is_addr(req.addr, acsif_pkg::ADDR_MODE_STATUS)
        |=> rd_data[acsif_pkg::MS_PENDING] == (|flags_q)) // RULE_10
        else $error("pending bit mismatch");
    AST_ENABLE: assert property (((flags & ~flags_q) & ~en_q) == 8'h00) // RULE_11
        else $error("flag set while disabled");
    AST_CLEAR: assert property (clear_evt && evt == 8'h00 |=> flags == 8'h00) // RULE_12
        else $error("flags not cleared");
    AST_FULL_EDGE: assert property ($rose(lvl_full) && cfg.int_en[acsif_pkg::FL_FULL]
        |=> flags[acsif_pkg::FL_FULL]) // RULE_16
        else $error("full flag not set");
    AST_CMB_HOLD: assert property (comb_evt && !cmd_apply |=> !armed [*1] ##0 !detector_run) // RULE_18
        else $error("detector still armed after detection");
    AST_REARM: assert property (clear_evt && cfg.rearm_detector_on_clear && !comb_evt
        && mode == acsif_pkg::M_COMBINED |=> armed) // RULE_19
        else $error("detector not re-armed on clear");

endmodule
`default_nettype wire
